// ===== hw/cfs_export.sv
// Configuration status export: per-function config fields mirrored to application outputs
//
// What this block does
// - Each function exports an 8-bit bus number from its config writes.
// - Each function exports a 5-bit device number from its config writes.
// - Exported bus/device numbers are informational; headers are filled elsewhere.
// - One memory decode enable bit per function mirrors command memory enable.
// - One request issue enable bit per function mirrors command bus master enable.
// - One VF memory decode enable bit per function mirrors SR-IOV control.
// - Each function exports its 16-bit programmed virtual function count.
// - Payload output is function zero's, else minimum over all functions.
// - Read request output is function zero's, else minimum over all functions.
// - Wide tag bit n mirrors device control bit 8 of function n.
// - Response timer off bit n mirrors device control 2 bit 4.
// - Atomic requester bit n mirrors device control 2 atomic requester enable.
// - Steering tag mode: two bits per function, TPH control bits 1:0.
// - Processing hint enable bit n mirrors TPH control bit 8.
// - Smallest translation unit: five bits per function, ATS control bits 4:0.
// - Translation service enable bit n mirrors ATS control bit 15.
// - Everything runs on the single application clock.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module cfs_export #(
  parameter int NUM_PF = 4
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  // Register bus slave
  input  wire logic [cfs_pkg::ADDR_W-1:0]         address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  input  wire logic [3:0]                         byteenable,
  output logic [31:0]                             readdata,
  output logic                                    waitrequest,
  // Exported configuration status
  output logic [8*NUM_PF-1:0]                     function_bus_number,
  output logic [5*NUM_PF-1:0]                     function_device_number,
  output logic [NUM_PF-1:0]                       pf_memory_decode_enable,
  output logic [NUM_PF-1:0]                       pf_request_issue_enable,
  output logic [NUM_PF-1:0]                       vf_memory_decode_enable,
  output logic [16*NUM_PF-1:0]                    pf_virtual_function_count,
  output logic [2:0]                              max_payload_size,
  output logic [2:0]                              max_read_request_size,
  output logic [NUM_PF-1:0]                       pf_wide_tag_enable,
  output logic [NUM_PF-1:0]                       pf_response_timer_off,
  output logic [NUM_PF-1:0]                       pf_atomic_requester_enable,
  output logic [2*NUM_PF-1:0]                     pf_steering_tag_mode,
  output logic [NUM_PF-1:0]                       pf_processing_hint_enable,
  output logic [5*NUM_PF-1:0]                     pf_smallest_translation_unit,
  output logic [NUM_PF-1:0]                       pf_translation_service_enable
);

  // Writable bits of a register, shared by write masking and nothing else
  function automatic logic [15:0] cfs_mask(input logic [2:0] idx);
    case (idx)
      cfs_pkg::REG_BUSDEV:   cfs_mask = cfs_pkg::MASK_BUSDEV;
      cfs_pkg::REG_COMMAND:  cfs_mask = cfs_pkg::MASK_COMMAND;
      cfs_pkg::REG_DEVCTL:   cfs_mask = cfs_pkg::MASK_DEVCTL;
      cfs_pkg::REG_DEVCTL2:  cfs_mask = cfs_pkg::MASK_DEVCTL2;
      cfs_pkg::REG_SRIOVCTL: cfs_mask = cfs_pkg::MASK_SRIOVCTL;
      cfs_pkg::REG_VIRTUAL_FUNCTION_COUNT_FIELD:   cfs_mask = cfs_pkg::MASK_VIRTUAL_FUNCTION_COUNT_FIELD;
      cfs_pkg::REG_TPHCTL:   cfs_mask = cfs_pkg::MASK_TPHCTL;
      default:               cfs_mask = cfs_pkg::MASK_ATSCTL;
    endcase
  endfunction

  // Reset value of a register
  function automatic logic [15:0] cfs_reset(input int idx);
    if (idx == int'(cfs_pkg::REG_DEVCTL)) begin
      cfs_reset = cfs_pkg::RST_DEVCTL;
    end else begin
      cfs_reset = cfs_pkg::RST_OTHER;
    end
  endfunction

  // Address decode: hits a present function's window
  function automatic logic cfs_pf_hit(input logic [cfs_pkg::ADDR_W-1:0] addr);
    cfs_pf_hit = (addr[9:8] == 2'h0) && (addr[5] == 1'b0) && (addr[1:0] == 2'h0)
                 && (int'(addr[7:6]) < NUM_PF);
  endfunction

  typedef enum logic [0:0] {
    CFS_IDLE = 1'b0,
    CFS_ACK  = 1'b1
  } cfs_bus_state_type;

  cfs_bus_state_type    bus_state_reg;
  logic [15:0]          cfg_mem_reg [NUM_PF][cfs_pkg::REG_COUNT];
  logic [31:0]          readdata_reg;
  logic                 request;
  logic                 commit;
  logic [1:0]           sel_pf;
  logic [2:0]           sel_reg;
  logic [15:0]          lane_mask;

  cfs_min_if #(.NUM_PF(NUM_PF)) min_bus ();

  assign request   = read | write;
  assign sel_pf    = address[7:6];
  assign sel_reg   = address[4:2];
  assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // Bus handshake: one wait cycle per access, then a single ack cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_state_reg <= CFS_IDLE;
    end else begin
      case (bus_state_reg)
        CFS_IDLE: if (request) bus_state_reg <= CFS_ACK;
        CFS_ACK:  bus_state_reg <= CFS_IDLE;
        default:  bus_state_reg <= CFS_IDLE;
      endcase
    end
  end

  // Waitrequest is high while idle, so a new request always sees a wait first
  assign waitrequest = (bus_state_reg != CFS_ACK);
  assign commit      = (bus_state_reg == CFS_ACK) && write;

  // Configuration field storage, written on the ack edge only
  // bus number captured
  generate
    for (genvar p = 0; p < NUM_PF; p++) begin : g_pf_store
      for (genvar r = 0; r < cfs_pkg::REG_COUNT; r++) begin : g_reg_store
        always_ff @(posedge mclk) begin
          if (!rst_n) begin
            cfg_mem_reg[p][r] <= cfs_reset(r);
          end else if (commit && cfs_pf_hit(address) && int'(sel_pf) == p && int'(sel_reg) == r) begin
            cfg_mem_reg[p][r] <= (cfg_mem_reg[p][r] & ~(cfs_mask(3'(r)) & lane_mask))
                                 | (writedata[15:0] & cfs_mask(3'(r)) & lane_mask);
          end
        end
      end
    end
  endgenerate

  // Read data captured on the wait cycle; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (bus_state_reg == CFS_IDLE && read) begin
      if (cfs_pf_hit(address)) begin
        readdata_reg <= {16'h0000, cfg_mem_reg[sel_pf][sel_reg]};
      end else if (address == cfs_pkg::STATUS_ADDR) begin
        readdata_reg <= {25'h0000000, max_read_request_size, 1'b0, max_payload_size};
      end else begin
        readdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign readdata = readdata_reg;

  // Per-function size fields feed the reducer
  generate
    for (genvar p = 0; p < NUM_PF; p++) begin : g_fields
      assign min_bus.payload_fields[3*p +: 3]  = cfg_mem_reg[p][cfs_pkg::REG_DEVCTL][cfs_pkg::MPS_LSB +: 3];
      assign min_bus.read_req_fields[3*p +: 3] = cfg_mem_reg[p][cfs_pkg::REG_DEVCTL][cfs_pkg::MRRS_LSB +: 3];
    end
  endgenerate

  cfs_min_reduce #(
    .NUM_PF (NUM_PF)
  ) u_min (
    .mins (min_bus.reducer)
  );

  // Export registers: one cycle behind storage, trading a cycle for clean outputs
  // single clock export
  generate
    for (genvar p = 0; p < NUM_PF; p++) begin : g_export
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          function_bus_number[8*p +: 8]          <= 8'h00;
          function_device_number[5*p +: 5]       <= 5'h00;
          pf_memory_decode_enable[p]             <= 1'b0;
          pf_request_issue_enable[p]             <= 1'b0;
          vf_memory_decode_enable[p]             <= 1'b0;
          pf_virtual_function_count[16*p +: 16]  <= 16'h0000;
          pf_wide_tag_enable[p]                  <= 1'b0;
          pf_response_timer_off[p]               <= 1'b0;
          pf_atomic_requester_enable[p]          <= 1'b0;
          pf_steering_tag_mode[2*p +: 2]         <= 2'h0;
          pf_processing_hint_enable[p]           <= 1'b0;
          pf_smallest_translation_unit[5*p +: 5] <= 5'h00;
          pf_translation_service_enable[p]       <= 1'b0;
        end else begin
          function_bus_number[8*p +: 8] <= cfg_mem_reg[p][cfs_pkg::REG_BUSDEV][cfs_pkg::BUS_LSB +: 8];
          function_device_number[5*p +: 5] <= cfg_mem_reg[p][cfs_pkg::REG_BUSDEV][cfs_pkg::DEV_LSB +: 5];
          pf_memory_decode_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_COMMAND][cfs_pkg::CMD_MEM_BIT];
          pf_request_issue_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_COMMAND][cfs_pkg::CMD_MAST_BIT];
          vf_memory_decode_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_SRIOVCTL][cfs_pkg::VFMSE_BIT];
          pf_virtual_function_count[16*p +: 16] <= cfg_mem_reg[p][cfs_pkg::REG_VIRTUAL_FUNCTION_COUNT_FIELD];
          pf_wide_tag_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_DEVCTL][cfs_pkg::XTAG_BIT];
          pf_response_timer_off[p] <= cfg_mem_reg[p][cfs_pkg::REG_DEVCTL2][cfs_pkg::CTO_BIT];
          pf_atomic_requester_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_DEVCTL2][cfs_pkg::ATOM_BIT];
          pf_steering_tag_mode[2*p +: 2] <= cfg_mem_reg[p][cfs_pkg::REG_TPHCTL][cfs_pkg::STMODE_LSB +: 2];
          pf_processing_hint_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_TPHCTL][cfs_pkg::TPHEN_BIT];
          pf_smallest_translation_unit[5*p +: 5] <= cfg_mem_reg[p][cfs_pkg::REG_ATSCTL][cfs_pkg::STU_LSB +: 5];
          pf_translation_service_enable[p] <= cfg_mem_reg[p][cfs_pkg::REG_ATSCTL][cfs_pkg::ATSEN_BIT];
        end
      end
    end
  endgenerate

  // Size outputs registered from the reducer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      max_payload_size      <= cfs_pkg::RST_DEVCTL[cfs_pkg::MPS_LSB +: 3];
      max_read_request_size <= cfs_pkg::RST_DEVCTL[cfs_pkg::MRRS_LSB +: 3];
    end else begin
      max_payload_size      <= min_bus.payload_min;
      max_read_request_size <= min_bus.read_req_min;
    end
  end

endmodule

// ===== hw/cfs_min_if.sv
// Interface: per-function size fields going to the minimum reducer and its results
`timescale 1ns/1ps
interface cfs_min_if #(
  parameter int NUM_PF = 4
);
  logic [3*NUM_PF-1:0] payload_fields;
  logic [3*NUM_PF-1:0] read_req_fields;
  logic [2:0]          payload_min;
  logic [2:0]          read_req_min;
  modport source  (output payload_fields, output read_req_fields, input payload_min, input read_req_min);
  modport reducer (input payload_fields, input read_req_fields, output payload_min, output read_req_min);
endinterface

// ===== hw/cfs_min_reduce.sv
// Minimum of the payload and read request size fields across all functions
`timescale 1ns/1ps
module cfs_min_reduce #(
  parameter int NUM_PF = 4
) (
  cfs_min_if.reducer mins
);
  generate
    if (NUM_PF == 1) begin : g_single
      assign mins.payload_min  = mins.payload_fields[2:0];
      assign mins.read_req_min = mins.read_req_fields[2:0];
    end else begin : g_multi
      logic [2:0] pay_min;
      logic [2:0] rd_min;
      always_comb begin
        pay_min = mins.payload_fields[2:0];
        rd_min  = mins.read_req_fields[2:0];
        for (int i = 1; i < NUM_PF; i++) begin
          if (mins.payload_fields[3*i +: 3] < pay_min) begin
            pay_min = mins.payload_fields[3*i +: 3];
          end
          if (mins.read_req_fields[3*i +: 3] < rd_min) begin
            rd_min = mins.read_req_fields[3*i +: 3];
          end
        end
      end
      assign mins.payload_min  = pay_min;
      assign mins.read_req_min = rd_min;
    end
  endgenerate
endmodule

// ===== hw/cfs_pkg.sv
// Package: register map, field layout and reset values of the config status export
package cfs_pkg;
  // Register indices within one function's register window
  localparam logic [2:0] REG_BUSDEV   = 3'h0;
  localparam logic [2:0] REG_COMMAND  = 3'h1;
  localparam logic [2:0] REG_DEVCTL   = 3'h2;
  localparam logic [2:0] REG_DEVCTL2  = 3'h3;
  localparam logic [2:0] REG_SRIOVCTL = 3'h4;
  localparam logic [2:0] REG_VIRTUAL_FUNCTION_COUNT_FIELD   = 3'h5;
  localparam logic [2:0] REG_TPHCTL   = 3'h6;
  localparam logic [2:0] REG_ATSCTL   = 3'h7;
  localparam int         REG_COUNT    = 8;
  localparam int         PF_MAX       = 4;
  localparam int         ADDR_W       = 10;
  // Window layout: byte address = pf * PF_STRIDE + reg * 4
  localparam int         PF_STRIDE    = 64;
  localparam logic [9:0] STATUS_ADDR  = 10'h100;
  // Bus and device number fields
  localparam int BUS_LSB      = 0;
  localparam int DEV_LSB      = 8;
  // Command register bits
  localparam int CMD_MEM_BIT  = 1;
  localparam int CMD_MAST_BIT = 2;
  // Device control fields
  localparam int MPS_LSB      = 5;
  localparam int XTAG_BIT     = 8;
  localparam int MRRS_LSB     = 12;
  // Device control 2 bits
  localparam int CTO_BIT      = 4;
  localparam int ATOM_BIT     = 6;
  // SR-IOV control bit
  localparam int VFMSE_BIT    = 3;
  // TPH requester control fields
  localparam int STMODE_LSB   = 0;
  localparam int TPHEN_BIT    = 8;
  // ATS control fields
  localparam int STU_LSB      = 0;
  localparam int ATSEN_BIT    = 15;
  // Writable bits of each register
  localparam logic [15:0] MASK_BUSDEV   = 16'h1fff;
  localparam logic [15:0] MASK_COMMAND  = 16'h0006;
  localparam logic [15:0] MASK_DEVCTL   = 16'h71e0;
  localparam logic [15:0] MASK_DEVCTL2  = 16'h0050;
  localparam logic [15:0] MASK_SRIOVCTL = 16'h0008;
  localparam logic [15:0] MASK_VIRTUAL_FUNCTION_COUNT_FIELD   = 16'hffff;
  localparam logic [15:0] MASK_TPHCTL   = 16'h0103;
  localparam logic [15:0] MASK_ATSCTL   = 16'h801f;
  // Values after reset; read request size comes up as 512 bytes
  localparam logic [15:0] RST_DEVCTL    = 16'h2000;
  localparam logic [15:0] RST_OTHER     = 16'h0000;
  // Bus answer latency: waitrequest drops one cycle after a request is seen
  localparam int          ACK_CYCLES    = 1;
endpackage

// ===== verification/cfs_app_model.sv
// Application side model: forms its requester ID from the exported numbers
`timescale 1ns/1ps
module cfs_app_model #(
  parameter int NUM_PF = 4
) (
  input  wire logic                 ari_on,
  input  wire logic [1:0]           pf_sel,
  input  wire logic [8*NUM_PF-1:0]  function_bus_number,
  input  wire logic [5*NUM_PF-1:0]  function_device_number,
  output logic [15:0]               requester_id
);
  // Device number is dropped in wide function numbering
  always_comb begin
    if (ari_on) begin
      requester_id = {function_bus_number[8*pf_sel +: 8], 6'h00, pf_sel};
    end else begin
      requester_id = {function_bus_number[8*pf_sel +: 8], function_device_number[5*pf_sel +: 5], 1'b0, pf_sel};
    end
  end
endmodule

// ===== verification/cfs_export_bench.sv
// Testbench: register bus sequences against the config status export
`timescale 1ns/1ps
module cfs_export_bench;
  localparam int NUM_PF = 4;
  localparam logic [15:0] PAT [4] = '{16'h5555, 16'h6666, 16'h7777, 16'h8888};
  localparam logic [15:0] MASKS [8] = '{cfs_pkg::MASK_BUSDEV, cfs_pkg::MASK_COMMAND, cfs_pkg::MASK_DEVCTL,
    cfs_pkg::MASK_DEVCTL2, cfs_pkg::MASK_SRIOVCTL, cfs_pkg::MASK_VIRTUAL_FUNCTION_COUNT_FIELD, cfs_pkg::MASK_TPHCTL, cfs_pkg::MASK_ATSCTL};
  localparam int STEP_PF [4] = '{3, 3, 0, 1};
  localparam logic [15:0] STEP_VAL [4] = '{16'h7000, 16'h70e0, 16'h3020, 16'h0000};
  logic                 mclk, rst_n, read, write, waitrequest, ari_on;
  logic [9:0]           address;
  logic [31:0]          writedata, readdata;
  logic [3:0]           byteenable;
  logic [1:0]           pf_sel;
  logic [15:0]          requester_id, d;
  logic [15:0]          dctl [NUM_PF];
  logic [6:0]           m;
  logic [2:0]           max_payload_size, max_read_request_size;
  logic [8*NUM_PF-1:0]  function_bus_number;
  logic [5*NUM_PF-1:0]  function_device_number, pf_smallest_translation_unit;
  logic [16*NUM_PF-1:0] pf_virtual_function_count;
  logic [2*NUM_PF-1:0]  pf_steering_tag_mode;
  logic [NUM_PF-1:0]    pf_memory_decode_enable, pf_request_issue_enable, vf_memory_decode_enable, pf_wide_tag_enable;
  logic [NUM_PF-1:0]    pf_response_timer_off, pf_atomic_requester_enable, pf_processing_hint_enable;
  logic [NUM_PF-1:0]    pf_translation_service_enable;
  int                   errors, checked;
  cfs_export #(.NUM_PF(NUM_PF)) cfs_export_inst (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .function_bus_number(function_bus_number), .function_device_number(function_device_number),
    .pf_memory_decode_enable(pf_memory_decode_enable), .pf_request_issue_enable(pf_request_issue_enable),
    .vf_memory_decode_enable(vf_memory_decode_enable), .pf_virtual_function_count(pf_virtual_function_count),
    .max_payload_size(max_payload_size), .max_read_request_size(max_read_request_size),
    .pf_wide_tag_enable(pf_wide_tag_enable), .pf_response_timer_off(pf_response_timer_off),
    .pf_atomic_requester_enable(pf_atomic_requester_enable), .pf_steering_tag_mode(pf_steering_tag_mode),
    .pf_processing_hint_enable(pf_processing_hint_enable), .pf_smallest_translation_unit(pf_smallest_translation_unit),
    .pf_translation_service_enable(pf_translation_service_enable));
  cfs_app_model #(.NUM_PF(NUM_PF)) cfs_app_model_inst (.ari_on(ari_on), .pf_sel(pf_sel),
    .function_bus_number(function_bus_number), .function_device_number(function_device_number),
    .requester_id(requester_id));
  // Free-running application clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus access; request held until waitrequest is sampled low, then one idle edge
  task automatic bus_cycle(input logic [9:0] a, input logic rd, input logic [31:0] wd, input logic [3:0] be,
                           output logic [31:0] q);
    int n;
    {address, read, write, writedata, byteenable} <= {a, rd, !rd, wd, be};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    {read, write} <= 2'b00;
    if (n == 20) begin
      errors++;
      end_of_test();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] q;
    bus_cycle(a, 1'b0, wd, be, q);
  endtask
  task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_cycle(a, 1'b1, 32'h0, 4'hf, q);
    check(name, exp, q);
  endtask
  // Minimum size fields over the shadow device control values
  function automatic logic [6:0] mins();
    logic [2:0] p;
    logic [2:0] r;
    p = 3'h7;
    r = 3'h7;
    for (int n = 0; n < NUM_PF; n++) begin
      if (dctl[n][7:5] < p) p = dctl[n][7:5];
      if (dctl[n][14:12] < r) r = dctl[n][14:12];
    end
    return {r, 1'b0, p};
  endfunction
  initial begin
    {rst_n, address, read, write, writedata, byteenable, ari_on, pf_sel} = '0;
    errors = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("read req reset", 32'h2, 32'(max_read_request_size));
    check("bus reset", 32'h0, function_bus_number);
    rd_chk("devctl reset", 10'h008, 32'h2000);
    // Distinct pattern per function into every register, upper half junk
    for (int n = 0; n < NUM_PF; n++) begin
      dctl[n] = PAT[n] & cfs_pkg::MASK_DEVCTL;
      for (int r = 0; r < 8; r++) wr(10'(n * 64 + r * 4), {16'hffff, PAT[n]}, 4'hf);
    end
    @(posedge mclk);
    for (int n = 0; n < NUM_PF; n++) begin
      d = PAT[n];
      check("bus", 32'(d[7:0]), 32'(function_bus_number[8*n +: 8]));
      check("device", 32'(d[12:8]), 32'(function_device_number[5*n +: 5]));
      check("command", 32'(d[2:1]), 32'({pf_request_issue_enable[n], pf_memory_decode_enable[n]}));
      check("vf mem", 32'(d[3]), 32'(vf_memory_decode_enable[n]));
      check("vf count", 32'(d), 32'(pf_virtual_function_count[16*n +: 16]));
      check("wide tag", 32'(d[8]), 32'(pf_wide_tag_enable[n]));
      check("timer off", 32'(d[4]), 32'(pf_response_timer_off[n]));
      check("atomic", 32'(d[6]), 32'(pf_atomic_requester_enable[n]));
      check("st mode", 32'(d[1:0]), 32'(pf_steering_tag_mode[2*n +: 2]));
      check("hint", 32'(d[8]), 32'(pf_processing_hint_enable[n]));
      check("stu", 32'(d[4:0]), 32'(pf_smallest_translation_unit[5*n +: 5]));
      check("ats", 32'(d[15]), 32'(pf_translation_service_enable[n]));
      for (int r = 0; r < 8; r++) rd_chk("readback", 10'(n * 64 + r * 4), 32'(d & MASKS[r]));
      {ari_on, pf_sel} <= {1'b0, 2'(n)};
      @(posedge mclk);
      check("plain id", {16'h0, d[7:0], d[12:8], 3'(n)}, 32'(requester_id));
      ari_on <= 1'b1;
      @(posedge mclk);
      check("ari id", {16'h0, d[7:0], 8'(n)}, 32'(requester_id));
    end
    // Size fields moved one function at a time; output is the minimum
    for (int i = 0; i < 4; i++) begin
      dctl[STEP_PF[i]] = STEP_VAL[i];
      wr(10'(STEP_PF[i] * 64 + 8), 32'(STEP_VAL[i]), 4'hf);
      @(posedge mclk);
      m = mins();
      check("payload min", 32'(m[2:0]), 32'(max_payload_size));
      check("read req min", 32'(m[6:4]), 32'(max_read_request_size));
      rd_chk("status", 10'h100, 32'(m));
    end
    // Single lane write, read-only status, unmapped place
    wr(10'h040, 32'h0000ffff, 4'h1);
    wr(10'h100, 32'hffffffff, 4'hf);
    wr(10'h104, 32'hffffffff, 4'hf);
    @(posedge mclk);
    check("lane bus", 32'hff, 32'(function_bus_number[15:8]));
    check("lane dev", 32'h06, 32'(function_device_number[9:5]));
    rd_chk("status ro", 10'h100, 32'(m));
    rd_chk("unmapped", 10'h104, 32'h0);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("bus rereset", 32'h0, function_bus_number);
    check("rrs rereset", 32'h2, 32'(max_read_request_size));
    rd_chk("devctl rereset", 10'h048, 32'h2000);
    rd_chk("busdev rereset", 10'h040, 32'h0);
    end_of_test();
  end
endmodule
bind cfs_export cfs_export_chk #(.NUM_PF(NUM_PF)) cfs_export_chk_inst (.mclk(mclk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .function_bus_number(function_bus_number),
  .function_device_number(function_device_number), .pf_memory_decode_enable(pf_memory_decode_enable),
  .pf_request_issue_enable(pf_request_issue_enable), .pf_virtual_function_count(pf_virtual_function_count),
  .pf_wide_tag_enable(pf_wide_tag_enable), .pf_smallest_translation_unit(pf_smallest_translation_unit),
  .pf_translation_service_enable(pf_translation_service_enable), .max_payload_size(max_payload_size),
  .max_read_request_size(max_read_request_size));

// ===== verification/cfs_export_chk.sv
// Checker: export mirroring and reset behaviour of the config status export
`timescale 1ns/1ps
module cfs_export_chk #(
  parameter int NUM_PF = 4
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic [9:0]            address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [3:0]            byteenable,
  input wire logic                  waitrequest,
  input wire logic [8*NUM_PF-1:0]   function_bus_number,
  input wire logic [5*NUM_PF-1:0]   function_device_number,
  input wire logic [NUM_PF-1:0]     pf_memory_decode_enable,
  input wire logic [NUM_PF-1:0]     pf_request_issue_enable,
  input wire logic [16*NUM_PF-1:0]  pf_virtual_function_count,
  input wire logic [NUM_PF-1:0]     pf_wide_tag_enable,
  input wire logic [5*NUM_PF-1:0]   pf_smallest_translation_unit,
  input wire logic [NUM_PF-1:0]     pf_translation_service_enable,
  input wire logic [2:0]            max_payload_size,
  input wire logic [2:0]            max_read_request_size
);
  logic wr_ok;
  // A write lands where waitrequest is seen low; exports follow two edges on
  assign wr_ok = write && !waitrequest;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_bus_number: assert property (
    wr_ok && address == 10'h000 && byteenable[0] |-> ##2 function_bus_number[7:0] == $past(writedata[7:0], 2))
    else $error("bus number not mirrored");
  chk_device_number: assert property (
    wr_ok && address == 10'h000 && byteenable[1] |-> ##2 function_device_number[4:0] == $past(writedata[12:8], 2))
    else $error("device number not mirrored");
  chk_command_bits: assert property (
    wr_ok && address == 10'h004 && byteenable[0]
    |-> ##2 {pf_request_issue_enable[0], pf_memory_decode_enable[0]} == $past(writedata[2:1], 2))
    else $error("command enables not mirrored");
  chk_vf_count: assert property (
    wr_ok && address == 10'h014 && byteenable[1:0] == 2'h3
    |-> ##2 pf_virtual_function_count[15:0] == $past(writedata[15:0], 2))
    else $error("vf count not mirrored");
  chk_wide_tag: assert property (
    wr_ok && address == 10'h008 && byteenable[1] |-> ##2 pf_wide_tag_enable[0] == $past(writedata[8], 2))
    else $error("wide tag not mirrored");
  chk_ats_fields: assert property (
    wr_ok && address == 10'h01c && byteenable[1:0] == 2'h3 |-> ##2
    {pf_translation_service_enable[0], pf_smallest_translation_unit[4:0]} == $past({writedata[15], writedata[4:0]}, 2))
    else $error("translation fields not mirrored");
  // Without writes the bus number and VF count exports must not drift
  chk_hold_quiet: assert property (
    !write [*3] |-> $stable(function_bus_number) && $stable(pf_virtual_function_count))
    else $error("export changed without a write");
  chk_reset_values: assert property (
    $rose(rst_n) |-> waitrequest && max_read_request_size == 3'h2 && function_bus_number == '0)
    else $error("reset values wrong");
  cov_write: cover property (wr_ok);
  cov_read: cover property (read && !waitrequest);
  cov_min_zero: cover property (max_payload_size == 3'h0 && max_read_request_size == 3'h0);
endmodule
